// file: core/tra_top.sv
// Register-access channel of an I/O terminal carried in the cyclic process
// image: control byte plus output word in, status byte plus input word out.
// Assumes the coupler logic runs on mclk and pulses pd_strobe once per new
// output image; din_pins are raw terminal inputs from outside the domain.
//
// Summary of operation
// - Control bit 7 set selects register access
// - Control bit 6 clear reads, set writes
// - Low six control bits give register index
// - Read ignores the output data word
// - Read acknowledge echoes control byte as status
// - Read returns addressed register in input word
// - Write acknowledge is control byte, bit 6 cleared
// - Locked: only code-word register accepts writes
// - Unlock value in code word opens writes
// - Other code word value restores protection
// - Changes retained, applied only after restart
// - Index nine returns two-character firmware version
// - Code-word register reads back last write
// - Feature register writable when unlocked, reads back
`timescale 1ns/100ps
`include "tra_consts.svh"

module tra_top
    import tra_pkg::*;
#(
    // Arbitrary version text, two ASCII characters
    parameter logic [`TRA_WORD_W-1:0] FW_VERSION = `TRA_FW_VERSION_DEFAULT
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic nvm_init_n,
    input wire logic pd_strobe,
    input wire logic [`TRA_BYTE_W-1:0] ctrl_byte,
    input wire logic [`TRA_WORD_W-1:0] output_data_word,
    input wire logic [`TRA_DIN_W-1:0] din_pins,
    output logic [`TRA_BYTE_W-1:0] status_byte,
    output logic [`TRA_WORD_W-1:0] input_data_word,
    output logic resp_strobe,
    output logic [`TRA_WORD_W-1:0] feature_active
);

    tra_top_s st_reg;
    tra_top_s st_next;

    logic rf_wr_en;
    logic [`TRA_WORD_W-1:0] rf_rdata;
    logic rf_wr_accepted;
    logic rf_unlocked;
    logic [`TRA_WORD_W-1:0] rf_code;
    logic [`TRA_WORD_W-1:0] rf_feature;

    function automatic logic is_reg_mode(input logic [`TRA_BYTE_W-1:0] c);
        is_reg_mode = c[`TRA_CTRL_REG_BIT];
    endfunction : is_reg_mode

    function automatic logic is_write(input logic [`TRA_BYTE_W-1:0] c);
        is_write = c[`TRA_CTRL_WR_BIT];
    endfunction : is_write

    function automatic logic [`TRA_IDX_W-1:0] reg_index(input logic [`TRA_BYTE_W-1:0] c);
        reg_index = c[`TRA_IDX_MSB:`TRA_IDX_LSB];
    endfunction : reg_index

    tra_regfile #(
        .FW_VERSION(FW_VERSION)
    ) u_regfile (
        .mclk(mclk),
        .nvm_init_n(nvm_init_n),
        .wr_en(rf_wr_en),
        .idx(reg_index(st_reg.cap_ctrl)),
        .wdata(st_reg.cap_data),
        .rdata(rf_rdata),
        .wr_accepted(rf_wr_accepted),
        .unlocked(rf_unlocked),
        .code_word(rf_code),
        .feature_stored(rf_feature)
    );

    // Writes only in the execute cycle; a read never strobes the store
    assign rf_wr_en = (st_reg.state == tra_st_exec) && is_reg_mode(st_reg.cap_ctrl)
        && is_write(st_reg.cap_ctrl);

    always_comb begin
        st_next = st_reg;
        st_next.din_s1 = din_pins;
        st_next.din_s2 = st_reg.din_s1;
        st_next.resp = 1'b0;
        case (st_reg.state)
            tra_st_idle: begin
                // Strobes arriving outside idle are dropped; the host
                // holds the image until it sees its acknowledge
                if (pd_strobe) begin
                    st_next.cap_ctrl = ctrl_byte;
                    st_next.cap_data = output_data_word;
                    st_next.state = tra_st_exec;
                end
            end
            tra_st_exec: begin
                st_next.state = tra_st_resp;
                st_next.resp = 1'b1;
                if (!is_reg_mode(st_reg.cap_ctrl)) begin
                    st_next.status = st_reg.din_s2;
                    st_next.in_word = `TRA_WORD_ZERO;
                end else if (is_write(st_reg.cap_ctrl)) begin
                    // Input word left as it was: its content is void
                    st_next.status = st_reg.cap_ctrl & `TRA_WR_ACK_MASK;
                end else begin
                    st_next.status = st_reg.cap_ctrl;
                    st_next.in_word = rf_rdata;
                end
            end
            tra_st_resp: begin
                st_next.state = tra_st_idle;
            end
            default: begin
                st_next.state = tra_st_idle;
            end
        endcase
        if (!resetn) begin
            st_next.state = tra_st_idle;
            st_next.cap_ctrl = `TRA_BYTE_ZERO;
            st_next.cap_data = `TRA_WORD_ZERO;
            st_next.din_s1 = `TRA_BYTE_ZERO;
            st_next.din_s2 = `TRA_BYTE_ZERO;
            st_next.status = `TRA_BYTE_ZERO;
            st_next.in_word = `TRA_WORD_ZERO;
            st_next.resp = 1'b0;
            // Restart is the only moment stored settings reach the terminal
            st_next.feature_active = rf_feature;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign status_byte = st_reg.status;
    assign input_data_word = st_reg.in_word;
    assign resp_strobe = st_reg.resp;
    assign feature_active = st_reg.feature_active;

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!resetn);

    sequence s_accept;
        st_reg.state == tra_st_idle && pd_strobe;
    endsequence

    sequence s_exec_read;
        st_reg.state == tra_st_exec && is_reg_mode(st_reg.cap_ctrl)
            && !is_write(st_reg.cap_ctrl);
    endsequence

    sequence s_exec_write;
        st_reg.state == tra_st_exec && is_reg_mode(st_reg.cap_ctrl)
            && is_write(st_reg.cap_ctrl);
    endsequence

    sequence s_exec_plain;
        st_reg.state == tra_st_exec && !is_reg_mode(st_reg.cap_ctrl);
    endsequence

    sequence s_busy;
        st_reg.state != tra_st_idle;
    endsequence

    property p_answer_timing;
        s_accept |-> !resp_strobe ##1 !resp_strobe ##1 resp_strobe ##1 !resp_strobe;
    endproperty

    a_answer_timing: assert property (p_answer_timing)
        else $error("answer strobe not two cycles after accept");

    a_read_ack_echo: assert property (
        s_exec_read |=> resp_strobe && status_byte == $past(st_reg.cap_ctrl))
        else $error("read acknowledge differs from control byte");

    a_read_data: assert property (
        s_exec_read |=> input_data_word == $past(rf_rdata))
        else $error("read data not the addressed register");

    a_read_no_side: assert property (
        s_exec_read |=> $stable(rf_code) && $stable(rf_feature))
        else $error("read access changed a register");

    a_write_ack: assert property (
        s_exec_write |=> status_byte == ($past(st_reg.cap_ctrl) & `TRA_WR_ACK_MASK)
            && status_byte[`TRA_CTRL_REG_BIT])
        else $error("write acknowledge wrong");

    a_locked_reject: assert property (
        (s_exec_write and (!rf_unlocked && reg_index(st_reg.cap_ctrl) == `TRA_IDX_FEATURE
            && nvm_init_n)) |=> $stable(rf_feature))
        else $error("feature register written while locked");

    a_code_always: assert property (
        (s_exec_write and (reg_index(st_reg.cap_ctrl) == `TRA_IDX_UNLOCK_CODE && nvm_init_n))
            |=> rf_code == $past(st_reg.cap_data))
        else $error("code word write lost");

    a_unlock_write: assert property (
        (s_exec_write and (rf_unlocked && reg_index(st_reg.cap_ctrl) == `TRA_IDX_FEATURE
            && nvm_init_n)) |=> rf_feature == $past(st_reg.cap_data))
        else $error("unlocked feature write lost");

    a_relock: assert property (
        (s_exec_write and (reg_index(st_reg.cap_ctrl) == `TRA_IDX_UNLOCK_CODE
            && st_reg.cap_data != `TRA_UNLOCK_VALUE)) |=> !rf_unlocked)
        else $error("protection not restored");

    a_fw_version: assert property (
        (s_exec_read and (reg_index(st_reg.cap_ctrl) == `TRA_IDX_FW_VERSION))
            |=> input_data_word == FW_VERSION)
        else $error("firmware version wrong");

    a_restart_apply: assert property (
        resetn && !$past(resetn) |-> feature_active == $past(rf_feature))
        else $error("feature not taken at restart");

    a_no_live_apply: assert property (
        $past(resetn) |-> $stable(feature_active))
        else $error("feature applied without restart");

    a_plain_mode: assert property (
        s_exec_plain |=> input_data_word == `TRA_WORD_ZERO
            && status_byte == $past(st_reg.din_s2) && $stable(rf_code) && $stable(rf_feature))
        else $error("register access outside register mode");

    a_take_ctrl: assert property (
        s_accept |=> st_reg.cap_ctrl == $past(ctrl_byte))
        else $error("control byte not captured at take");

    a_take_data: assert property (
        s_accept |=> st_reg.cap_data == $past(output_data_word))
        else $error("output word not captured at take");

    a_busy_drop: assert property (
        s_busy |=> $stable(st_reg.cap_ctrl) && $stable(st_reg.cap_data))
        else $error("request taken while busy");

    a_resp_single: assert property (
        resp_strobe |=> !resp_strobe)
        else $error("answer strobe longer than one cycle");

    a_status_hold: assert property (
        $past(resetn) && !resp_strobe |-> $stable(status_byte))
        else $error("status byte changed without an answer");

    a_word_hold: assert property (
        $past(resetn) && !resp_strobe |-> $stable(input_data_word))
        else $error("input word changed without an answer");

    a_write_word_kept: assert property (
        s_exec_write |=> $stable(input_data_word))
        else $error("write acknowledge changed the input word");

    a_read_regbit: assert property (
        s_exec_read |=> status_byte[`TRA_CTRL_REG_BIT] && !status_byte[`TRA_CTRL_WR_BIT])
        else $error("read acknowledge lost the mode bits");

    a_read_no_write: assert property (
        s_exec_read |-> !rf_wr_en)
        else $error("read access strobed the store");

    a_plain_no_write: assert property (
        s_exec_plain |-> !rf_wr_en)
        else $error("store strobed outside register mode");

    a_wr_gate: assert property (
        rf_wr_accepted && !rf_unlocked |-> reg_index(st_reg.cap_ctrl) == `TRA_IDX_UNLOCK_CODE)
        else $error("locked store accepted a write");

    a_unlock_open: assert property (
        (s_exec_write and (reg_index(st_reg.cap_ctrl) == `TRA_IDX_UNLOCK_CODE
            && st_reg.cap_data == `TRA_UNLOCK_VALUE && nvm_init_n)) |=> rf_unlocked)
        else $error("unlock value did not open writes");

    a_read_keeps_lock: assert property (
        (s_exec_read and nvm_init_n) |=> $stable(rf_unlocked))
        else $error("read access changed the write protection");

    a_fw_readonly: assert property (
        (s_exec_write and (reg_index(st_reg.cap_ctrl) == `TRA_IDX_FW_VERSION && nvm_init_n))
            |=> $stable(rf_code) && $stable(rf_feature))
        else $error("firmware version index accepted a write");

    a_unmapped_zero: assert property (
        (s_exec_read and (reg_index(st_reg.cap_ctrl) != `TRA_IDX_FW_VERSION
            && reg_index(st_reg.cap_ctrl) != `TRA_IDX_UNLOCK_CODE
            && reg_index(st_reg.cap_ctrl) != `TRA_IDX_FEATURE))
            |=> input_data_word == `TRA_WORD_ZERO)
        else $error("unmapped index did not read zero");

    a_store_quiet: assert property (
        !rf_wr_en && nvm_init_n |=> $stable(rf_code) && $stable(rf_feature))
        else $error("store changed without a write");

    a_reset_clear: assert property (
        $rose(resetn) |-> status_byte == `TRA_BYTE_ZERO && input_data_word == `TRA_WORD_ZERO
            && !resp_strobe)
        else $error("outputs not cleared by restart");

endmodule : tra_top

// file: common/tra_consts.svh
// Constants of the terminal register-access channel: control byte layout,
// register indices, unlock value and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TRA_CONSTS_SVH
`define TRA_CONSTS_SVH

`define TRA_BYTE_W 8
`define TRA_WORD_W 16
`define TRA_DIN_W 8
`define TRA_IDX_W 6
`define TRA_CTRL_REG_BIT 7
`define TRA_CTRL_WR_BIT 6
`define TRA_IDX_MSB 5
`define TRA_IDX_LSB 0
`define TRA_IDX_FW_VERSION 6'h09
`define TRA_IDX_UNLOCK_CODE 6'h1f
`define TRA_IDX_FEATURE 6'h20
`define TRA_UNLOCK_VALUE 16'h1235
`define TRA_CODE_RESET 16'h0000
`define TRA_FEATURE_RESET 16'h0000
`define TRA_WR_ACK_MASK 8'hbf
`define TRA_WORD_ZERO 16'h0000
`define TRA_BYTE_ZERO 8'h00
// Arbitrary version text, two ASCII characters
`define TRA_FW_VERSION_DEFAULT 16'h3130

`endif

// file: common/tra_pkg.sv
// Types of the terminal register-access channel: sequencer states and the
// packed state records of the two design modules.
// Assumes tra_consts.svh is on the include path.
package tra_pkg;

`include "tra_consts.svh"

    typedef enum logic [2:0] {
        tra_st_idle = 3'b001,
        tra_st_exec = 3'b010,
        tra_st_resp = 3'b100
    } tra_state_e;

    typedef struct packed {
        tra_state_e state;
        logic [`TRA_BYTE_W-1:0] cap_ctrl;
        logic [`TRA_WORD_W-1:0] cap_data;
        logic [`TRA_DIN_W-1:0] din_s1;
        logic [`TRA_DIN_W-1:0] din_s2;
        logic [`TRA_BYTE_W-1:0] status;
        logic [`TRA_WORD_W-1:0] in_word;
        logic resp;
        logic [`TRA_WORD_W-1:0] feature_active;
    } tra_top_s;

    typedef struct packed {
        logic [`TRA_WORD_W-1:0] code_word;
        logic [`TRA_WORD_W-1:0] feature;
    } tra_rf_s;

endpackage : tra_pkg

// file: core/tra_regfile.sv
// Retained register store of the register-access channel: code word and
// feature register, write protection, and the read multiplexer.
// Assumes a single clock mclk; the store survives resetn and is cleared only
// by nvm_init_n, standing in for blank non-volatile memory.
`timescale 1ns/100ps
`include "tra_consts.svh"

module tra_regfile
    import tra_pkg::*;
#(
    parameter logic [`TRA_WORD_W-1:0] FW_VERSION = `TRA_FW_VERSION_DEFAULT
) (
    input wire logic mclk,
    input wire logic nvm_init_n,
    input wire logic wr_en,
    input wire logic [`TRA_IDX_W-1:0] idx,
    input wire logic [`TRA_WORD_W-1:0] wdata,
    output logic [`TRA_WORD_W-1:0] rdata,
    output logic wr_accepted,
    output logic unlocked,
    output logic [`TRA_WORD_W-1:0] code_word,
    output logic [`TRA_WORD_W-1:0] feature_stored
);

    tra_rf_s st_reg;
    tra_rf_s st_next;

    // Only the code word is open while locked
    function automatic logic writable(input logic [`TRA_IDX_W-1:0] i, input logic open);
        writable = (i == `TRA_IDX_UNLOCK_CODE) || (open && (i == `TRA_IDX_FEATURE));
    endfunction : writable

    function automatic logic [`TRA_WORD_W-1:0] read_mux(input logic [`TRA_IDX_W-1:0] i,
                                                        input tra_rf_s s);
        case (i)
            `TRA_IDX_FW_VERSION: read_mux = FW_VERSION;
            `TRA_IDX_UNLOCK_CODE: read_mux = s.code_word;
            `TRA_IDX_FEATURE: read_mux = s.feature;
            default: read_mux = `TRA_WORD_ZERO;
        endcase
    endfunction : read_mux

    always_comb begin
        unlocked = (st_reg.code_word == `TRA_UNLOCK_VALUE);
        wr_accepted = wr_en && writable(idx, unlocked);
        rdata = read_mux(idx, st_reg);
        st_next = st_reg;
        if (!nvm_init_n) begin
            st_next.code_word = `TRA_CODE_RESET;
            st_next.feature = `TRA_FEATURE_RESET;
        end else if (wr_accepted) begin
            if (idx == `TRA_IDX_UNLOCK_CODE) begin
                st_next.code_word = wdata;
            end else begin
                st_next.feature = wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign code_word = st_reg.code_word;
    assign feature_stored = st_reg.feature;

endmodule : tra_regfile

// file: verif/tra_host_model.sv
// Host-side model of the bus coupler: puts one request into the process
// image and holds it until the terminal answers with resp_strobe.
// Assumes the terminal takes pd_strobe on rising mclk, one take at a time.
`timescale 1ns/100ps

module tra_host_model (
    input wire logic mclk,
    input wire logic resp_strobe,
    output logic pd_strobe,
    output logic [7:0] ctrl_byte,
    output logic [15:0] output_data_word,
    output logic tmo
);
    initial begin
        pd_strobe = 1'b0;
        ctrl_byte = 8'h00;
        output_data_word = 16'h0000;
        tmo = 1'b0;
    end

    // Gap gives prompt or slow hosts; a read carries a noisy data word
    task automatic request(input logic [7:0] ctrl, input logic [15:0] word, input int gap);
        int n;
        repeat (gap) @(posedge mclk);
        #1;
        ctrl_byte = ctrl;
        output_data_word = ctrl[6] ? word : 16'($urandom);
        pd_strobe = 1'b1;
        @(posedge mclk);
        #1;
        pd_strobe = 1'b0;
        n = 0;
        // Image is held unchanged until the matching answer
        while (resp_strobe !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20) begin
            tmo = 1'b1;
        end
        @(posedge mclk);
        #1;
        output_data_word = ~output_data_word;
    endtask : request
endmodule : tra_host_model

// file: verif/tb.sv
// Self-checking bench of the register-access channel: a host model sends
// requests, expectations go into a queue, a monitor checks every answer.
// Assumes tra_top answers every taken request with one resp_strobe pulse.
`timescale 1ns/100ps

module tb;
    localparam logic [15:0] FW = 16'h4b37; // Arbitrary version text
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic nvm_init_n = 1'b0;
    logic [7:0] din_pins = 8'h00;
    logic pd_strobe, resp_strobe, tmo;
    logic [7:0] ctrl_byte, status_byte;
    logic [15:0] output_data_word, input_data_word, feature_active;
    logic [24:0] exp_q[$];
    logic [24:0] e;
    logic [5:0] idx_tab[4] = '{6'h00, 6'h1e, 6'h21, 6'h3f};
    int n_fail = 0;
    int comparisons = 0;

    always #5 mclk = ~mclk;

    tra_top #(.FW_VERSION(FW)) dut (
        .mclk(mclk),
        .resetn(resetn),
        .nvm_init_n(nvm_init_n),
        .pd_strobe(pd_strobe),
        .ctrl_byte(ctrl_byte),
        .output_data_word(output_data_word),
        .din_pins(din_pins),
        .status_byte(status_byte),
        .input_data_word(input_data_word),
        .resp_strobe(resp_strobe),
        .feature_active(feature_active)
    );

    tra_host_model host (
        .mclk(mclk),
        .resp_strobe(resp_strobe),
        .pd_strobe(pd_strobe),
        .ctrl_byte(ctrl_byte),
        .output_data_word(output_data_word),
        .tmo(tmo)
    );

    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Monitor: each answer is paired with the oldest expectation
    always @(negedge mclk) begin
        if (resp_strobe === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[FAIL] t=%0t got=%h exp=none", $time, status_byte);
            end else begin
                e = exp_q.pop_front();
                check({8'h00, status_byte}, {8'h00, e[23:16]});
                if (e[24]) begin
                    check(input_data_word, e[15:0]);
                end
            end
        end
    end

    task automatic xfer(input logic [7:0] ctrl, input logic [15:0] word,
                        input logic [7:0] st, input logic [15:0] rd, input logic chk);
        exp_q.push_back({chk, st, rd});
        host.request(ctrl, word, $urandom_range(3));
        if (tmo === 1'b1) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            results();
        end
    endtask : xfer

    task automatic rd(input logic [5:0] idx, input logic [15:0] val);
        xfer({2'b10, idx}, 16'h0000, {2'b10, idx}, val, 1'b1);
    endtask : rd

    // Input word after a write acknowledge is not looked at
    task automatic wr(input logic [5:0] idx, input logic [15:0] val);
        xfer({2'b11, idx}, val, {2'b10, idx}, 16'h0000, 1'b0);
    endtask : wr

    initial begin
        void'($urandom(5));
        repeat (8) @(posedge mclk);
        #1;
        resetn = 1'b1;
        nvm_init_n = 1'b1;
        rd(6'h09, FW);
        wr(6'h20, 16'hbeef);
        rd(6'h20, 16'h0000);
        $display("test locked access done");
        wr(6'h1f, 16'h1235);
        rd(6'h1f, 16'h1235);
        wr(6'h20, 16'h0002);
        rd(6'h20, 16'h0002);
        wr(6'h09, 16'h5555);
        rd(6'h09, FW);
        check(feature_active, 16'h0000);
        $display("test unlocked access done");
        wr(6'h1f, 16'h0000);
        wr(6'h20, 16'h00ff);
        rd(6'h20, 16'h0002);
        for (int i = 0; i < 4; i++) begin
            rd(idx_tab[i], 16'h0000);
        end
        $display("test relock done");
        @(posedge mclk);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        check(feature_active, 16'h0002);
        rd(6'h1f, 16'h0000);
        rd(6'h20, 16'h0002);
        $display("test restart done");
        din_pins = 8'($urandom);
        repeat (5) @(posedge mclk);
        xfer({2'b00, 6'($urandom)}, 16'h1235, din_pins, 16'h0000, 1'b1);
        rd(6'h20, 16'h0002);
        repeat (4) @(posedge mclk);
        check(16'(exp_q.size()), 16'h0000);
        $display("test normal mode done");
        results();
    end
endmodule : tb
